// ==== src/crf_rx_filter.sv ====
// can receive fifo with six scalable identifier filter banks and a wishbone slave
// Operation
// - empty fifo plus valid message stores it, shows it, pending count becomes 01b.
// - release decrements pending count; next stored message appears in the mailbox.
// - unreleased mailbox: further messages fill free slots, count goes 10b then 11b.
// - message arriving with all three slots full sets the overrun flag.
// - lock cleared: overrun overwrites the newest stored entry with the incoming one.
// - lock set: overrun discards the incoming message, three oldest kept.
// - count moving 00b to 01b interrupts when pending interrupt enable is set.
// - storing a third message sets full flag, interrupts if full enable set.
// - overrun sets overrun flag, interrupts if overrun enable set.
// - messages passing no active filter are dropped without software.
// - six filter banks of eight bytes, each with its own two-bit scale.
// - scale 3 is one 32-bit filter, bytes 0-3 identifier, 4-7 mask or identifier.
// - 32-bit byte layout: std 10:3; std 2:0,rtr,ide,ext 17:15; ext 14:7; ext 6:0.
// - scale 2 is two 16-bit filters: 0/1 with 2/3, and 4/5 with 6/7.
// - scale 0 is four 8-bit filters on std 10:3, pairs 0/1,2/3,4/5,6/7.
// - scale 1 is one 16-bit filter in bytes 0-3 and 8-bit filters 4/5, 6/7.
// - mask mode: a set mask bit means must match, clear means don't care.
// - list mode: mask bytes are a second identifier; exact match with either accepts.
// - a message is valid only if received without error and it passed filtering.
// - per bank, one mode bit for the low filter bytes, one for the high bytes.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps

module crf_rx_filter
  import crf_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // frames from the protocol core
  input  wire logic        rx_done_i,
  input  wire logic        rx_error_i,
  input  wire crf_frame_t  rx_frame_i,
  // interrupt request
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] mod3_add(input logic [1:0] a, input logic [1:0] b);
    logic [2:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 3'd3)
    begin
      s = s - 3'd3;
    end
    return s[1:0];
  endfunction

  // one filter: care limits compared bits, list selects identifier-list mode
  function automatic logic filt_hit(input logic [31:0] id, input logic [31:0] a,
                                    input logic [31:0] b, input logic list,
                                    input logic [31:0] care);
    logic hit;
    hit = 1'b0;
    if (list)
    begin
      hit = (((id ^ a) & care) == 32'h0) || (((id ^ b) & care) == 32'h0);
    end
    else
    begin
      hit = ((id ^ a) & b & care) == 32'h0;
    end
    return hit;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]       fbyte_reg [NUM_BANKS*BANK_BYTES];
  logic [1:0]       scale_reg [NUM_BANKS];
  logic [NUM_BANKS-1:0] active_reg;
  logic [NUM_BANKS-1:0] mode_lo_reg;
  logic [NUM_BANKS-1:0] mode_hi_reg;
  logic             lock_en_reg;
  logic [2:0]       irq_en_reg;
  crf_frame_t       mbox_reg [FIFO_DEPTH];
  logic [1:0]       rd_ptr_reg;
  logic [1:0]       count_reg;
  logic             full_reg;
  logic             ovr_reg;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic        bus_req;
  logic        bus_wr;
  logic        in_bank;
  logic [5:0]  bank_word;
  logic        release_wr;
  logic        full_clr;
  logic        ovr_clr;

  assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr     = bus_req && wb_we_i;
  assign in_bank    = (wb_adr_i >= FILTER_BANK_BASE_OFS) && (wb_adr_i <= FILTER_BANK_END_OFS);
  assign bank_word  = 6'(wb_adr_i - FILTER_BANK_BASE_OFS);
  assign release_wr = bus_wr && (wb_adr_i == RX_FIFO_CTRL_OFS) && wb_sel_i[0]
                      && wb_dat_i[RELEASE_BIT];
  assign full_clr   = bus_wr && (wb_adr_i == RX_FIFO_CTRL_OFS) && wb_sel_i[0]
                      && wb_dat_i[FULL_BIT];
  assign ovr_clr    = bus_wr && (wb_adr_i == RX_FIFO_CTRL_OFS) && wb_sel_i[0]
                      && wb_dat_i[OVR_BIT];

  // ---------------------------------------------------------------
  // acceptance filtering
  // ---------------------------------------------------------------
  logic [31:0]          in_id;
  logic [NUM_BANKS-1:0] bank_hit;
  logic                 store_req;

  // byte0 is the most significant byte of the compare word
  assign in_id = {rx_frame_i.std_id[10:3],
                  rx_frame_i.std_id[2:0], rx_frame_i.rtr, rx_frame_i.ide,
                  rx_frame_i.ext_id[17:15],
                  rx_frame_i.ext_id[14:7],
                  rx_frame_i.ext_id[6:0], 1'b0};

  for (genvar g = 0; g < NUM_BANKS; g++)
  begin : g_bank
    logic [31:0] lo4;
    logic [31:0] hi4;
    logic [31:0] c16;
    logic [31:0] c8;
    logic        h32;
    logic        h16a;
    logic        h16b;
    logic        h8a;
    logic        h8b;
    logic        h8c;
    logic        h8d;
    assign lo4  = {fbyte_reg[g*8+0], fbyte_reg[g*8+1], fbyte_reg[g*8+2], fbyte_reg[g*8+3]};
    assign hi4  = {fbyte_reg[g*8+4], fbyte_reg[g*8+5], fbyte_reg[g*8+6], fbyte_reg[g*8+7]};
    assign c16  = 32'hffff_0000;
    assign c8   = 32'hff00_0000;
    // 32-bit filter: both mode bits are expected equal, the low one is used
    assign h32  = filt_hit(in_id, lo4, hi4, mode_lo_reg[g], 32'hffff_ffff);
    assign h16a = filt_hit(in_id, {lo4[31:16], 16'h0}, {lo4[15:0], 16'h0},
                           mode_lo_reg[g], c16);
    assign h16b = filt_hit(in_id, {hi4[31:16], 16'h0}, {hi4[15:0], 16'h0},
                           mode_hi_reg[g], c16);
    assign h8a  = filt_hit(in_id, {lo4[31:24], 24'h0}, {lo4[23:16], 24'h0},
                           mode_lo_reg[g], c8);
    assign h8b  = filt_hit(in_id, {lo4[15:8], 24'h0}, {lo4[7:0], 24'h0},
                           mode_lo_reg[g], c8);
    assign h8c  = filt_hit(in_id, {hi4[31:24], 24'h0}, {hi4[23:16], 24'h0},
                           mode_hi_reg[g], c8);
    assign h8d  = filt_hit(in_id, {hi4[15:8], 24'h0}, {hi4[7:0], 24'h0},
                           mode_hi_reg[g], c8);

    always_comb
    begin
      case (crf_scale_t'(scale_reg[g]))
        SCALE_ONE_32: bank_hit[g] = active_reg[g] && h32;
        SCALE_TWO_16: bank_hit[g] = active_reg[g] && (h16a || h16b);
        SCALE_MIXED:  bank_hit[g] = active_reg[g] && (h16a || h8c || h8d);
        SCALE_FOUR_8: bank_hit[g] = active_reg[g] && (h8a || h8b || h8c || h8d);
        default:      bank_hit[g] = 1'b0;
      endcase
    end
  end

  // frames with errors or no filter hit never reach the fifo
  assign store_req = rx_done_i && !rx_error_i && (|bank_hit);

  // ---------------------------------------------------------------
  // receive fifo
  // ---------------------------------------------------------------
  logic       do_release;
  logic       overrun;
  logic       do_write;
  logic [1:0] wr_idx;
  logic [1:0] count_next;

  assign do_release = release_wr && (count_reg != PEND_EMPTY);
  // a release in the same cycle frees a slot, so that arrival is no overrun
  assign overrun    = store_req && (count_reg == PEND_THREE) && !do_release;
  assign do_write   = store_req && !(overrun && lock_en_reg);
  // overrun without lock targets the newest entry, else the next free slot
  assign wr_idx     = overrun ? mod3_add(rd_ptr_reg, PEND_TWO)
                              : mod3_add(rd_ptr_reg, count_reg);

  always_comb
  begin
    count_next = count_reg;
    if (store_req && !overrun && !do_release)
    begin
      count_next = count_reg + 2'h1;
    end
    else if (do_release && !store_req)
    begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && do_write)
    begin
      mbox_reg[wr_idx] <= rx_frame_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_ptr_reg <= 2'h0;
      count_reg  <= PEND_EMPTY;
    end
    else if (ce_i)
    begin
      count_reg <= count_next;
      if (do_release)
      begin
        rd_ptr_reg <= mod3_add(rd_ptr_reg, 2'h1);
      end
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      full_reg <= 1'b0;
      ovr_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (count_reg != PEND_THREE && count_next == PEND_THREE)
      begin
        full_reg <= 1'b1;
      end
      else if (full_clr)
      begin
        full_reg <= 1'b0;
      end
      if (overrun)
      begin
        ovr_reg <= 1'b1;
      end
      else if (ovr_clr)
      begin
        ovr_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  logic pend_evt_reg;

  // pending event is sticky until the fifo drains back to empty
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_evt_reg <= 1'b0;
      irq_o        <= 1'b0;
    end
    else if (ce_i)
    begin
      if (count_reg == PEND_EMPTY && count_next == PEND_ONE)
      begin
        pend_evt_reg <= 1'b1;
      end
      else if (count_reg == PEND_EMPTY)
      begin
        pend_evt_reg <= 1'b0;
      end
      irq_o <= (irq_en_reg[IE_PEND_BIT] && pend_evt_reg)
            || (irq_en_reg[IE_FULL_BIT] && full_reg)
            || (irq_en_reg[IE_OVR_BIT] && ovr_reg);
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_en_reg <= CTRL_RST[0];
      irq_en_reg  <= CTRL_RST[2:0];
      active_reg  <= '0;
      mode_lo_reg <= '0;
      mode_hi_reg <= '0;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        scale_reg[b] <= 2'h0;
      end
    end
    else if (ce_i && bus_wr && wb_sel_i[0])
    begin
      case (wb_adr_i)
        CAN_MASTER_CTRL_OFS: lock_en_reg <= wb_dat_i[LOCK_BIT];
        CAN_IRQ_ENABLE_OFS:  irq_en_reg  <= wb_dat_i[IE_OVR_BIT:IE_PEND_BIT];
        FILTER_MODE_OFS:     mode_lo_reg <= wb_dat_i[NUM_BANKS-1:0];
        FILTER_CFG_OFS:
        begin
          for (int b = 0; b < NUM_BANKS; b++)
          begin
            scale_reg[b]  <= wb_dat_i[b*CFG_BANK_W +: 2];
            active_reg[b] <= wb_dat_i[b*CFG_BANK_W + CFG_ACT_BIT];
          end
        end
        default: ;
      endcase
    end
    if (!rst_i && ce_i && bus_wr && wb_sel_i[1] && wb_adr_i == FILTER_MODE_OFS)
    begin
      mode_hi_reg <= wb_dat_i[MODE_HIGH_LSB +: NUM_BANKS];
    end
  end

  // filter bytes: byte lane n of a bank word holds byte 4*word+n
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_BANKS*BANK_BYTES; i++)
      begin
        fbyte_reg[i] <= FILTER_BYTE_RST;
      end
    end
    else if (ce_i && bus_wr && in_bank)
    begin
      for (int n = 0; n < 4; n++)
      begin
        if (wb_sel_i[n])
        begin
          fbyte_reg[{bank_word[5:2], 2'(n)}] <= wb_dat_i[n*8 +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux and acknowledge
  // ---------------------------------------------------------------
  logic [31:0] rd_data;
  crf_frame_t  head;

  assign head = mbox_reg[rd_ptr_reg];

  always_comb
  begin
    rd_data = 32'h0;
    if (in_bank)
    begin
      for (int n = 0; n < 4; n++)
      begin
        rd_data[n*8 +: 8] = fbyte_reg[{bank_word[5:2], 2'(n)}];
      end
    end
    else
    begin
      case (wb_adr_i)
        RX_FIFO_CTRL_OFS:
        begin
          rd_data[PEND_LSB +: 2] = count_reg;
          rd_data[FULL_BIT]      = full_reg;
          rd_data[OVR_BIT]       = ovr_reg;
        end
        CAN_MASTER_CTRL_OFS: rd_data[LOCK_BIT] = lock_en_reg;
        CAN_IRQ_ENABLE_OFS:  rd_data[2:0] = irq_en_reg;
        FILTER_CFG_OFS:
        begin
          for (int b = 0; b < NUM_BANKS; b++)
          begin
            rd_data[b*CFG_BANK_W +: 2]           = scale_reg[b];
            rd_data[b*CFG_BANK_W + CFG_ACT_BIT]  = active_reg[b];
          end
        end
        FILTER_MODE_OFS:
        begin
          rd_data[NUM_BANKS-1:0]              = mode_lo_reg;
          rd_data[MODE_HIGH_LSB +: NUM_BANKS] = mode_hi_reg;
        end
        MBOX_ID_OFS:
        begin
          rd_data[ID_EXT_LSB +: 18] = head.ext_id;
          rd_data[ID_STD_LSB +: 11] = head.std_id;
          rd_data[ID_IDE_BIT]       = head.ide;
          rd_data[ID_RTR_BIT]       = head.rtr;
        end
        MBOX_DLC_OFS:     rd_data[3:0] = head.dlc;
        MBOX_DATA_LO_OFS: rd_data = head.data[31:0];
        MBOX_DATA_HI_OFS: rd_data = head.data[63:32];
        default:          rd_data = 32'h0;
      endcase
    end
  end

  // one wait state: ack follows the request edge and drops the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rd_data : 32'h0;
    end
  end

endmodule

// ==== src/crf_pkg.sv ====
// package: register map, field positions and frame carrier for the can receive block
package crf_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] RX_FIFO_CTRL_OFS     = 8'h00;
  localparam logic [7:0] CAN_MASTER_CTRL_OFS  = 8'h04;
  localparam logic [7:0] CAN_IRQ_ENABLE_OFS   = 8'h08;
  localparam logic [7:0] FILTER_CFG_OFS       = 8'h0c;
  localparam logic [7:0] FILTER_MODE_OFS      = 8'h10;
  localparam logic [7:0] MBOX_ID_OFS          = 8'h20;
  localparam logic [7:0] MBOX_DLC_OFS         = 8'h24;
  localparam logic [7:0] MBOX_DATA_LO_OFS     = 8'h28;
  localparam logic [7:0] MBOX_DATA_HI_OFS     = 8'h2c;
  localparam logic [7:0] FILTER_BANK_BASE_OFS = 8'h40;
  localparam logic [7:0] FILTER_BANK_END_OFS  = 8'h6f;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PEND_LSB      = 0;
  localparam int FULL_BIT      = 2;
  localparam int OVR_BIT       = 3;
  localparam int RELEASE_BIT   = 4;
  localparam int LOCK_BIT      = 0;
  localparam int IE_PEND_BIT   = 0;
  localparam int IE_FULL_BIT   = 1;
  localparam int IE_OVR_BIT    = 2;
  localparam int CFG_BANK_W    = 3;
  localparam int CFG_ACT_BIT   = 2;
  localparam int MODE_HIGH_LSB = 8;
  localparam int ID_EXT_LSB    = 0;
  localparam int ID_STD_LSB    = 18;
  localparam int ID_IDE_BIT    = 29;
  localparam int ID_RTR_BIT    = 30;

  // ---------------------------------------------------------------
  // sizes, codes and reset values
  // ---------------------------------------------------------------
  localparam int NUM_BANKS  = 6;
  localparam int BANK_BYTES = 8;
  localparam int FIFO_DEPTH = 3;

  localparam logic [1:0] PEND_EMPTY = 2'h0;
  localparam logic [1:0] PEND_ONE   = 2'h1;
  localparam logic [1:0] PEND_TWO   = 2'h2;
  localparam logic [1:0] PEND_THREE = 2'h3;

  localparam logic [7:0]  FILTER_BYTE_RST = 8'h00;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;

  typedef enum logic [1:0] {
    SCALE_FOUR_8  = 2'b00,
    SCALE_MIXED   = 2'b01,
    SCALE_TWO_16  = 2'b10,
    SCALE_ONE_32  = 2'b11
  } crf_scale_t;

  typedef struct packed {
    logic [10:0] std_id;
    logic        ide;
    logic [17:0] ext_id;
    logic        rtr;
    logic [3:0]  dlc;
    logic [63:0] data;
  } crf_frame_t;

endpackage

// ==== sim/crf_rx_filter_props.sv ====
// checker: bus, reset and interrupt relations at the receive block ports
`timescale 1ns/10ps

module crf_rx_filter_props
  import crf_pkg::*;
(
  // clock, reset, enable
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // frames and interrupt
  input wire logic        rx_done_i,
  input wire logic        rx_error_i,
  input wire crf_frame_t  rx_frame_i,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----
  // helpers
  // ----
  logic wr_ack;
  assign wr_ack = wb_ack_o & wb_we_i;

  sequence req_taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence bus_cycle_s;
    req_taken_s ##1 wb_ack_o;
  endsequence

  // ----
  // assertions
  // ----
  ack_latency_a: assert property (req_taken_s |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_single_a: assert property (bus_cycle_s |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  wr_dat_zero_a: assert property (wr_ack |-> wb_dat_o == 32'h0)
    else $error("read data on write ack");
  reset_quiet_a: assert property ($past(rst_i) |-> !irq_o && !wb_ack_o)
    else $error("outputs active after reset");
  // an interrupt only follows a taken frame or a register write
  irq_rise_a: assert property ($rose(irq_o) |-> $past(rx_done_i, 2) || $past(wr_ack)
    || $past(wr_ack, 2)) else $error("interrupt raised without cause");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_ack) || $past(wr_ack, 2))
    else $error("interrupt dropped without write");
  unmapped_zero_a: assert property (req_taken_s ##0 (!wb_we_i && wb_adr_i >= 8'h70)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule

// ==== sim/crf_core_model.sv ====
// partner model: protocol core handing finished frames to the receive block
`timescale 1ns/10ps

module crf_core_model
  import crf_pkg::*;
(
  // clock
  input wire logic  clk_i,
  // frame output
  output logic       rx_done_o,
  output logic       rx_error_o,
  output crf_frame_t rx_frame_o
);
  initial
  begin
    rx_done_o = 1'b0;
    rx_error_o = 1'b0;
    rx_frame_o = '0;
  end

  // gap gives prompt and slow delivery; after the pulse the frame lines
  // show the inverse so a stale frame is never mistaken for a fresh one
  task automatic send_frame(input crf_frame_t f, input logic err, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    rx_done_o <= 1'b1;
    rx_error_o <= err;
    rx_frame_o <= f;
    @(posedge clk_i);
    rx_done_o <= 1'b0;
    rx_error_o <= ~err;
    rx_frame_o <= ~f;
  endtask
endmodule

// ==== sim/crf_rx_filter_bench.sv ====
// testbench: register access, identifier filtering and receive fifo scenarios
`timescale 1ns/10ps

module crf_rx_filter_bench
  import crf_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        irq;
  logic        rx_done;
  logic        rx_error;
  crf_frame_t  rx_frame;
  logic [31:0] rd_val;
  int          err_count;
  int          check_count;

  crf_rx_filter i_crf_rx_filter (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rx_done_i(rx_done),
    .rx_error_i(rx_error), .rx_frame_i(rx_frame), .irq_o(irq)
  );
  crf_core_model i_crf_core_model (
    .clk_i(clk), .rx_done_o(rx_done), .rx_error_o(rx_error), .rx_frame_o(rx_frame)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----
  // tasks
  // ----
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // values are read before the edge's updates land, i.e. as sampled there
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    @(posedge clk);
    while (wb_ack !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 16)
      err_count++;
    rd_val = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(rd_val, exp);
  endtask

  task automatic send(input logic [10:0] sid, input logic [7:0] tg, input logic err);
    crf_frame_t f;
    f = '{std_id: sid, ide: 1'b0, ext_id: 18'h0, rtr: 1'b0, dlc: 4'h8, data: {56'h0, tg}};
    i_crf_core_model.send_frame(f, err, int'(tg[1:0]));
  endtask

  task automatic pop(input logic [10:0] sid, input logic [7:0] tg);
    rd_chk(MBOX_ID_OFS, {3'h0, sid, 18'h0});
    rd_chk(MBOX_DATA_LO_OFS, {24'h0, tg});
    rd_chk(MBOX_DLC_OFS, 32'h8);
    bus(1'b1, RX_FIFO_CTRL_OFS, 32'h10);
  endtask

  // ----
  // tests
  // ----
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    err_count = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h0);
    rd_chk(FILTER_BANK_BASE_OFS, 32'h0);
    rd_chk(8'h70, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test reset_state done");
    // bank 0: one 32-bit mask filter on std id 0x123; bank 1: 8-bit list ids
    bus(1'b1, FILTER_BANK_BASE_OFS, 32'h0000_6024);
    bus(1'b1, 8'h44, 32'h0000_e0ff);
    bus(1'b1, 8'h48, 32'h3131_3130);
    bus(1'b1, 8'h4c, 32'h3131_3131);
    bus(1'b1, FILTER_MODE_OFS, 32'h0000_0202);
    bus(1'b1, FILTER_CFG_OFS, 32'h0000_0027);
    rd_chk(8'h48, 32'h3131_3130);
    bus(1'b1, CAN_IRQ_ENABLE_OFS, 32'h1);
    send(11'h123, 8'ha1, 1'b0);
    send(11'h124, 8'hb0, 1'b0);
    send(11'h170, 8'hb1, 1'b0);
    send(11'h123, 8'hb2, 1'b1);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h1);
    check({31'h0, irq}, 32'h1);
    send(11'h18f, 8'ha2, 1'b0);
    send(11'h180, 8'ha3, 1'b0);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h7);
    send(11'h123, 8'ha4, 1'b0);
    rd_chk(RX_FIFO_CTRL_OFS, 32'hf);
    bus(1'b1, RX_FIFO_CTRL_OFS, 32'hc);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h3);
    pop(11'h123, 8'ha1);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h2);
    pop(11'h18f, 8'ha2);
    pop(11'h123, 8'ha4);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test overwrite done");
    bus(1'b1, CAN_MASTER_CTRL_OFS, 32'h1);
    bus(1'b1, CAN_IRQ_ENABLE_OFS, 32'h2);
    send(11'h180, 8'hc1, 1'b0);
    send(11'h18f, 8'hc2, 1'b0);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h2);
    check({31'h0, irq}, 32'h0);
    send(11'h123, 8'hc3, 1'b0);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h7);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, CAN_IRQ_ENABLE_OFS, 32'h4);
    check({31'h0, irq}, 32'h0);
    send(11'h123, 8'hc4, 1'b0);
    rd_chk(RX_FIFO_CTRL_OFS, 32'hf);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, RX_FIFO_CTRL_OFS, 32'hc);
    pop(11'h180, 8'hc1);
    pop(11'h18f, 8'hc2);
    pop(11'h123, 8'hc3);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h0);
    $display("test lock done");
    // bank 0 two 16-bit filters, low mask and high list; bank 1 mixed, 8-bit filters list
    bus(1'b1, FILTER_BANK_BASE_OFS, 32'h00ff_0055);
    bus(1'b1, 8'h44, 32'he07f_6024);
    bus(1'b1, 8'h48, 32'hffff_0001);
    bus(1'b1, 8'h4c, 32'h1414_1312);
    bus(1'b1, FILTER_MODE_OFS, 32'h0000_0300);
    bus(1'b1, FILTER_CFG_OFS, 32'h0000_002e);
    rd_chk(FILTER_MODE_OFS, 32'h0000_0300);
    send(11'h2af, 8'hd1, 1'b0);
    send(11'h3fe, 8'hd2, 1'b0);
    send(11'h3ff, 8'hd3, 1'b0);
    send(11'h009, 8'hd4, 1'b0);
    send(11'h008, 8'hd5, 1'b0);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h7);
    pop(11'h2af, 8'hd1);
    pop(11'h3ff, 8'hd3);
    pop(11'h008, 8'hd5);
    // a frame offered while the clock enable is low must leave no trace
    ce <= 1'b0;
    send(11'h098, 8'he6, 1'b0);
    ce <= 1'b1;
    rd_chk(RX_FIFO_CTRL_OFS, 32'h4);
    send(11'h098, 8'hd6, 1'b0);
    pop(11'h098, 8'hd6);
    bus(1'b1, RX_FIFO_CTRL_OFS, 32'hc);
    rd_chk(RX_FIFO_CTRL_OFS, 32'h0);
    $display("test scale done");
    end_sim();
  end

  initial
  begin
    repeat (4000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule

bind crf_rx_filter crf_rx_filter_props i_crf_rx_filter_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_done_i(rx_done_i),
  .rx_error_i(rx_error_i), .rx_frame_i(rx_frame_i), .irq_o(irq_o)
);
